/* dv/analog_comparator_dac_control_bench.sv */
// Purpose: Self-checking bench for the comparator bank control.
// Assumes: One clk per instruction cycle; inputs change on rising edges.
// Notes: Outputs are sampled on the falling edge, where they have settled.
`timescale 1ns/1ns
module analog_comparator_dac_control_bench;
  import analog_comparator_dac_control_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic [NUM_COMP-1:0] compRaw = '0;
  logic idleMode = 1'b0;
  logic sleepMode = 1'b0;
  comp_cfg_t compCfg [NUM_COMP];
  logic [NUM_COMP-1:0] compConditioned, compTrigger, wakeRequest, faultLatched;
  logic irq;
  logic [7:0] adcStarts;
  int failures = 0;
  int samplesChecked = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  analog_comparator_dac_control u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .compRaw(compRaw), .idleMode(idleMode), .sleepMode(sleepMode), .compCfg(compCfg),
    .compConditioned(compConditioned), .compTrigger(compTrigger),
    .wakeRequest(wakeRequest), .irq(irq));
  comparator_far_side u_far (.clk(clk), .rst_n(rst_n), .conditioned(compConditioned),
    .trigger(compTrigger), .adcStarts(adcStarts), .faultLatched(faultLatched));
  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdchk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp, string what);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRdata, exp, what);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic setRaw(logic [NUM_COMP-1:0] v);
    @(posedge clk);
    compRaw <= v;
  endtask
  task automatic t_reset();
    chk(compCfg[0], 16'h0000, "cfg reset");
    rdchk(ADDR_CTRL_BASE, 16'h0000, "ctrl reset");
    rdchk(ADDR_DAC_BASE + 4'h3, 16'h0000, "dac reset");
    rdchk(ADDR_INT_MASK, 16'h0000, "mask reset");
    wr(4'hA, 16'hFFFF);
    rdchk(4'hA, 16'h0000, "unmapped");
  endtask
  task automatic t_fields();
    // Pin output enabled on comparator 0 only
    wr(ADDR_CTRL_BASE, 16'hFFFD);
    cyc(1);
    chk(compCfg[0].enable, 16'h0001, "enable");
    chk(compCfg[0].refSelect, REF_EXTERNAL, "external_reference_select");
    chk(compCfg[0].dacPinEnable, 16'h0001, "dac pin");
    rdchk(ADDR_CTRL_BASE, 16'hA1E1, "ctrl mask");
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL_BASE, 16'h8000 | 16'(s << 6) | 16'(s % 2));
      cyc(1);
      chk(compCfg[0].inputSelect, 16'(s), "insel");
      chk(compCfg[0].refSelect, (s % 2) ? REF_HALF_AVDD : REF_INTERNAL, "range");
    end
    wr(ADDR_DAC_BASE + 4'h1, 16'hFFFF);
    cyc(1);
    chk(compCfg[1].dacValue, 16'h03FF, "dac max");
    rdchk(ADDR_DAC_BASE + 4'h1, 16'h03FF, "dac read");
  endtask
  task automatic t_filter();
    int hits;
    hits = 0;
    wr(ADDR_INT_MASK, 16'h0001);
    wr(ADDR_CTRL_BASE, 16'h8000);
    setRaw(4'h1);
    setRaw(4'h0);
    repeat (6) begin
      @(negedge clk);
      if (compConditioned[0] !== 1'b0) hits++;
    end
    chk(16'(hits), 16'h0000, "glitch passed");
    setRaw(4'h1);
    repeat (6) begin
      @(negedge clk);
      if (compTrigger[0] === 1'b1) hits++;
    end
    chk(16'(hits), 16'h0001, "pulse width");
    chk(compConditioned[0], 16'h0001, "held level");
    chk(irq, 16'h0001, "irq set");
    chk(adcStarts, 16'h0001, "adc start");
    chk(faultLatched[0], 16'h0001, "fault latch");
    rdchk(ADDR_INT_STATUS, 16'h0001, "status");
    rdchk(ADDR_CTRL_BASE, 16'h8008, "state bit");
    wr(ADDR_INT_MASK, 16'h0000);
    cyc(1);
    chk(irq, 16'h0000, "irq masked");
    wr(ADDR_INT_MASK, 16'h0001);
    wr(ADDR_INT_STATUS, 16'h0001);
    cyc(1);
    chk(irq, 16'h0000, "irq cleared");
  endtask
  task automatic t_polarity();
    setRaw(4'h0);
    wr(ADDR_CTRL_BASE, 16'h8002);
    cyc(3);
    chk(compConditioned[0], 16'h0001, "inverted");
    rdchk(ADDR_CTRL_BASE, 16'h800A, "state inverted");
    setRaw(4'h1);
    cyc(3);
    chk(compConditioned[0], 16'h0000, "inverted low");
    wr(ADDR_CTRL_BASE, 16'h8000);
  endtask
  task automatic t_lowpower();
    wr(ADDR_CTRL_BASE + 4'h1, 16'h2000);
    @(posedge clk);
    idleMode <= 1'b1;
    cyc(2);
    chk(compConditioned[0], 16'h0000, "idle stop");
    chk(compCfg[0].enable, 16'h0000, "idle off");
    wr(ADDR_CTRL_BASE + 4'h1, 16'h0000);
    cyc(2);
    chk(compConditioned[0], 16'h0001, "idle run");
    chk(wakeRequest[0], 16'h0001, "idle wake");
    @(posedge clk);
    idleMode <= 1'b0;
    sleepMode <= 1'b1;
    compRaw <= 4'h0;
    @(negedge clk);
    chk(wakeRequest[0], 16'h0000, "sleep low");
    setRaw(4'h1);
    @(negedge clk);
    chk(wakeRequest[0], 16'h0001, "sleep wake");
    @(posedge clk);
    sleepMode <= 1'b0;
    wr(ADDR_CTRL_BASE, 16'h0000);
    cyc(1);
    chk(compCfg[0].enable, 16'h0000, "disable");
    chk(compConditioned[0], 16'h0000, "disabled out");
  endtask
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole run is about 100 cycles; allow ample margin
  initial begin
    #(CLK_PERIOD_NS * 5000);
    failures++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_fields();
    t_filter();
    t_polarity();
    t_lowpower();
    stop_test();
  end
endmodule

/* dv/comparator_far_side.sv */
// Purpose: Far-side model of the ADC trigger input and the PWM fault latch.
// Assumes: Pulses and levels arrive synchronous to clk.
// Notes: Fault latch clears only on reset, as a PWM fault latch would.
`timescale 1ns/1ns
module comparator_far_side
  import analog_comparator_dac_control_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_COMP-1:0] conditioned,
  input wire logic [NUM_COMP-1:0] trigger,
  output logic [7:0] adcStarts,
  output logic [NUM_COMP-1:0] faultLatched
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adcStarts <= 8'h00;
    end else if (trigger[0]) begin
      adcStarts <= adcStarts + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      faultLatched <= '0;
    end else begin
      faultLatched <= faultLatched | conditioned;
    end
  end
endmodule

/* src/analog_comparator_dac_control.sv */
// Purpose: Control, glitch filter and event pulses for a bank of comparators.
// Assumes: compRaw, idleMode and sleepMode are synchronous to clk.
// Notes: wakeRequest is the only output not taken from a flip-flop.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module analog_comparator_dac_control
  import analog_comparator_dac_control_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  input wire logic [NUM_COMP-1:0] compRaw,
  input wire logic idleMode,
  input wire logic sleepMode,
  output comp_cfg_t compCfg [NUM_COMP],
  output logic [NUM_COMP-1:0] compConditioned,
  output logic [NUM_COMP-1:0] compTrigger,
  output logic [NUM_COMP-1:0] wakeRequest,
  output logic irq
);

  logic [DATA_W-1:0] ctrl_reg [NUM_COMP];
  logic [DAC_W-1:0] dac_reg [NUM_COMP];
  logic [1:0] cnt_reg [NUM_COMP];
  logic [1:0] cnt_next [NUM_COMP];
  comp_cfg_t cfg_reg [NUM_COMP];
  logic [DATA_W-1:0] ctrlView [NUM_COMP];
  ref_sel_t refSel [NUM_COMP];
  logic [NUM_COMP-1:0] status_reg;
  logic [NUM_COMP-1:0] status_next;
  logic [NUM_COMP-1:0] mask_reg;
  logic [NUM_COMP-1:0] filt_reg;
  logic [NUM_COMP-1:0] filt_next;
  logic [NUM_COMP-1:0] pulse_reg;
  logic [NUM_COMP-1:0] pulse_next;
  logic [NUM_COMP-1:0] active;
  logic [NUM_COMP-1:0] polRaw;
  logic [NUM_COMP-1:0] diff;
  logic [NUM_COMP-1:0] flip;
  logic [NUM_COMP-1:0] stopIdle;
  logic [NUM_COMP-1:0] hitCtrl;
  logic [NUM_COMP-1:0] hitDac;
  logic [NUM_COMP-1:0] statusClr;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic irq_reg;

  wire lowPower = idleMode | sleepMode;
  wire anyStopIdle = |stopIdle;
  wire hitStatus = regAddr == ADDR_INT_STATUS;
  wire hitMask = regAddr == ADDR_INT_MASK;

  // W1C, and a new event in the same cycle wins over the clear
  assign statusClr = (regWrite & hitStatus) ? regWdata[NUM_COMP-1:0] : INT_RESET;
  assign status_next = (status_reg & ~statusClr) | pulse_next;

  genvar i;
  generate
    for (i = 0; i < NUM_COMP; i++) begin : g_comp
      assign hitCtrl[i] = regAddr == (ADDR_CTRL_BASE + ADDR_W'(i));
      assign hitDac[i] = regAddr == (ADDR_DAC_BASE + ADDR_W'(i));
      assign stopIdle[i] = ctrl_reg[i][CTRL_STOP_IDLE_BIT];
      assign active[i] = ctrl_reg[i][CTRL_ENABLE_BIT] & ~(idleMode & anyStopIdle);
      assign polRaw[i] = active[i] & (compRaw[i] ^ ctrl_reg[i][CTRL_POL_BIT]);
      assign diff[i] = polRaw[i] != filt_reg[i];
      // flip only after a full filter span of disagreement
      assign flip[i] = diff[i] & (cnt_reg[i] == GLITCH_CNT_LAST);
      // low power takes the unfiltered value
      assign filt_next[i] = !active[i] ? 1'b0 : (lowPower ? polRaw[i] : filt_reg[i] ^ flip[i]);
      assign cnt_next[i] = (!active[i] | lowPower | !diff[i] | flip[i]) ? 2'h0
                           : 2'(cnt_reg[i] + 2'h1);
      // single cycle pulse on rising conditioned output
      assign pulse_next[i] = filt_next[i] & ~filt_reg[i];
      // unclocked wake path while the clock may be stopped
      assign wakeRequest[i] = lowPower & polRaw[i];
      assign refSel[i] = ctrl_reg[i][CTRL_EXTERNAL_REFERENCE_SELECT_BIT] ? REF_EXTERNAL
                         : (ctrl_reg[i][CTRL_RANGE_BIT] ? REF_HALF_AVDD : REF_INTERNAL);
      // live state folded into the read view
      assign ctrlView[i] = ctrl_reg[i] | (DATA_W'(polRaw[i]) << CTRL_STATE_BIT);

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ctrl_reg[i] <= CTRL_RESET;
        end else if (regWrite && hitCtrl[i]) begin
          ctrl_reg[i] <= regWdata & CTRL_WRITE_MASK;
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dac_reg[i] <= DAC_RESET;
        end else if (regWrite && hitDac[i]) begin
          dac_reg[i] <= regWdata[DAC_W-1:0] & DAC_WRITE_MASK[DAC_W-1:0];
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cnt_reg[i] <= 2'h0;
        end else begin
          cnt_reg[i] <= cnt_next[i];
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cfg_reg[i] <= '0;
        end else begin
          cfg_reg[i].enable <= active[i];
          cfg_reg[i].inputSelect <= input_sel_t'(ctrl_reg[i][CTRL_INSEL_MSB:CTRL_INSEL_LSB]);
          cfg_reg[i].refSelect <= refSel[i];
          cfg_reg[i].dacValue <= dac_reg[i];
          // pin enables passed as written while active; exclusivity is software's job
          cfg_reg[i].dacPinEnable <= active[i] & ctrl_reg[i][CTRL_DAC_PIN_BIT];
        end
      end

      assign compCfg[i] = cfg_reg[i];

      sequence shortBlip;
        (active[i] && !lowPower && diff[i] && cnt_reg[i] == 2'h0)
          ##1 (active[i] && !lowPower && !diff[i]);
      endsequence

      sequence longRun;
        (active[i] && !lowPower && diff[i] && cnt_reg[i] == 2'h0)
          ##1 (active[i] && !lowPower && diff[i]);
      endsequence

      comp_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_reg[i][CTRL_ENABLE_BIT] |=> !compCfg[i].enable && !compCfg[i].dacPinEnable)
        else $error("disabled comparator still powered");

      idle_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (idleMode && anyStopIdle) |=> !compCfg[i].enable && !compConditioned[i])
        else $error("comparator active in idle with stop set");

      glitch_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        shortBlip |=> compConditioned[i] == $past(compConditioned[i], 2))
        else $error("one cycle glitch reached output");

      glitch_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        longRun |=> compConditioned[i] == $past(polRaw[i]))
        else $error("two cycle level did not pass filter");

      filter_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lowPower && active[i]) |=>
          compConditioned[i] == $past(compRaw[i] ^ ctrl_reg[i][CTRL_POL_BIT]))
        else $error("filter not bypassed in low power");

      pulse_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        compTrigger[i] |-> (compConditioned[i] && !$past(compConditioned[i])) ##1 !compTrigger[i])
        else $error("trigger pulse wrong width or cause");

      wake_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lowPower && active[i]) |-> wakeRequest[i] == (compRaw[i] ^ ctrl_reg[i][CTRL_POL_BIT]))
        else $error("wake path polarity wrong");

      input_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && hitCtrl[i]) |=> ##1
          compCfg[i].inputSelect == $past(regWdata[CTRL_INSEL_MSB:CTRL_INSEL_LSB], 2))
        else $error("input select not applied");

      ref_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && hitCtrl[i] && regWdata[CTRL_EXTERNAL_REFERENCE_SELECT_BIT]) |=> ##1
          compCfg[i].refSelect == REF_EXTERNAL)
        else $error("external reference not selected");

      dac_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && hitDac[i]) |=> ##1 compCfg[i].dacValue == $past(regWdata[DAC_W-1:0], 2))
        else $error("dac code not applied");

      event_fanout_a: assert property (@(posedge clk) disable iff (!rst_n)
        compTrigger[i] |-> status_reg[i] && compConditioned[i])
        else $error("event did not reach all consumers");

      status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && hitCtrl[i]) |=> regRdata[CTRL_STATE_BIT] == $past(polRaw[i])
          && regRdata[4] == 1'b0 && regRdata[14] == 1'b0)
        else $error("control readback wrong");

      idle_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        (idleMode && !anyStopIdle && ctrl_reg[i][CTRL_ENABLE_BIT]) |=> compCfg[i].enable)
        else $error("comparator stopped in idle without stop bit");

      wake_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !lowPower |-> !wakeRequest[i])
        else $error("wake request outside low power");

      ref_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && hitCtrl[i] && !regWdata[CTRL_EXTERNAL_REFERENCE_SELECT_BIT]) |=> ##1
          compCfg[i].refSelect == ($past(regWdata[CTRL_RANGE_BIT], 2)
          ? REF_HALF_AVDD : REF_INTERNAL))
        else $error("range bit not applied");

      status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && hitStatus && regWdata[i] && !pulse_next[i]) |=> !status_reg[i])
        else $error("status bit not cleared by one");

      status_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        pulse_next[i] |=> status_reg[i] && compTrigger[i])
        else $error("event lost against clear");

      dac_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && hitDac[i]) |=> regRdata[DATA_W-1:DAC_W] == '0)
        else $error("dac reserved bits not zero");
    end
  endgenerate

  always_comb begin
    rdata_next = '0;
    for (int k = 0; k < NUM_COMP; k++) begin
      if (hitCtrl[k]) begin
        rdata_next = ctrlView[k];
      end
      if (hitDac[k]) begin
        rdata_next = {{(DATA_W-DAC_W){1'b0}}, dac_reg[k]};
      end
    end
    if (hitStatus) begin
      rdata_next = {{(DATA_W-NUM_COMP){1'b0}}, status_reg};
    end
    if (hitMask) begin
      rdata_next = {{(DATA_W-NUM_COMP){1'b0}}, mask_reg};
    end
    if (!regRead) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_reg <= '0;
      pulse_reg <= '0;
    end else begin
      filt_reg <= filt_next;
      pulse_reg <= pulse_next;
    end
  end

  // sticky event status feeding the interrupt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= INT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_reg <= INT_RESET;
    end else if (regWrite && hitMask) begin
      mask_reg <= regWdata[NUM_COMP-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign regRdata = rdata_reg;
  assign compConditioned = filt_reg;
  assign compTrigger = pulse_reg;
  assign irq = irq_reg;

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((|(status_reg & mask_reg)) && $stable(mask_reg)) |-> irq)
    else $error("unmasked status without interrupt");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (regRead && regAddr > ADDR_INT_MASK) |=> regRdata == '0)
    else $error("unmapped read not zero");

endmodule

/* src/analog_comparator_dac_control_pkg.sv */
// Purpose: Shared constants and carrier types for the comparator bank control.
// Assumes: One instruction cycle equals one clk period at 50 MHz.
// Notes: Register offsets are word indices on the plain register port.
package analog_comparator_dac_control_pkg;

  localparam int NUM_COMP = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int DAC_W = 10;
  localparam int DAC_FULL_SCALE = 1024;

  localparam logic [ADDR_W-1:0] ADDR_CTRL_BASE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DAC_BASE = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 4'h9;

  localparam int CTRL_ENABLE_BIT = 15;
  localparam int CTRL_STOP_IDLE_BIT = 13;
  localparam int CTRL_DAC_PIN_BIT = 8;
  localparam int CTRL_INSEL_MSB = 7;
  localparam int CTRL_INSEL_LSB = 6;
  localparam int CTRL_EXTERNAL_REFERENCE_SELECT_BIT = 5;
  localparam int CTRL_STATE_BIT = 3;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_RANGE_BIT = 0;

  localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 16'hA1E3;
  localparam logic [DATA_W-1:0] DAC_WRITE_MASK = 16'h03FF;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DAC_W-1:0] DAC_RESET = 10'h000;
  localparam logic [NUM_COMP-1:0] INT_RESET = 4'h0;

  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_CYCLE_NS = 20;
  // Glitch filter span in instruction cycles, converted to clocks
  localparam int GLITCH_INSTR_CYCLES = 2;
  localparam int GLITCH_CLKS = (GLITCH_INSTR_CYCLES * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam logic [1:0] GLITCH_CNT_LAST = 2'(GLITCH_CLKS - 1);

  typedef enum logic [1:0] {
    INPUT_A = 2'h0,
    INPUT_B = 2'h1,
    INPUT_C = 2'h2,
    INPUT_D = 2'h3
  } input_sel_t;

  typedef enum logic [1:0] {
    REF_HALF_AVDD = 2'h0,
    REF_INTERNAL = 2'h1,
    REF_EXTERNAL = 2'h2
  } ref_sel_t;

  typedef struct packed {
    logic enable;
    input_sel_t inputSelect;
    ref_sel_t refSelect;
    logic [DAC_W-1:0] dacValue;
    logic dacPinEnable;
  } comp_cfg_t;

endpackage
